// File: logic/dsm_chan_regs.sv
// Purpose: one channel's decimation page register set
// Assumes: writes and reads strobed by the bus slave
// Notes: reserved bits read back as zero
`timescale 1ns/1ns
`default_nettype none
module dsm_chan_regs
	import dsm_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// access
	input wire logic wr_en,
	input wire logic [15:0] idx,
	input wire logic [7:0] wdata,
	// config out
	output dsm_chan_cfg_t cfg,
	output logic [7:0] rdata,
	output logic hit,
	output logic bad_write
);
	logic en_q, dual_q, real_q, src_q;
	logic [3:0] dec_q;

	// --------------------------------
	// registers
	// --------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q <= DSM_RST_CTRL[DSM_BIT_ENABLE];
			dec_q <= DSM_RST_CTRL[3:0];
			dual_q <= DSM_RST_CTRL[DSM_BIT_DUAL];
			real_q <= DSM_RST_CTRL[DSM_BIT_REAL];
			src_q <= DSM_RST_CTRL[DSM_BIT_SOURCE];
		end else if (wr_en) begin
			unique case (idx)
				DSM_IDX_ENABLE: en_q <= wdata[DSM_BIT_ENABLE];
				DSM_IDX_DECIM: dec_q <= wdata[3:0];
				DSM_IDX_DUAL: dual_q <= wdata[DSM_BIT_DUAL];
				DSM_IDX_REAL: real_q <= wdata[DSM_BIT_REAL];
				DSM_IDX_SOURCE: src_q <= wdata[DSM_BIT_SOURCE];
				default: begin
				end
			endcase
		end
	end

	// --------------------------------
	// decode
	// --------------------------------
	always_comb begin
		rdata = 8'h00;
		hit = 1'b1;
		bad_write = 1'b0;
		unique case (idx)
			DSM_IDX_ENABLE: begin
				rdata = {7'h00, en_q};
				bad_write = |(wdata & DSM_RSV_ONEBIT);
			end
			DSM_IDX_DECIM: begin
				rdata = {4'h0, dec_q};
				bad_write = |(wdata & DSM_RSV_DECIM) || wdata[3:0] == DSM_DECIM_UNUSED_A
					|| wdata[3:0] == DSM_DECIM_UNUSED_B || wdata[3:0] > DSM_DECIM_MAX;
			end
			DSM_IDX_DUAL: begin
				rdata = {7'h00, dual_q};
				bad_write = |(wdata & DSM_RSV_ONEBIT);
			end
			DSM_IDX_REAL: begin
				rdata = {7'h00, real_q};
				bad_write = |(wdata & DSM_RSV_ONEBIT);
			end
			DSM_IDX_SOURCE: begin
				rdata = {7'h00, src_q};
				bad_write = |(wdata & DSM_RSV_ONEBIT);
			end
			default: hit = 1'b0;
		endcase
	end

	assign cfg = '{downconv_enable: en_q, decimation_ratio_sel: dec_q, dual_band: dual_q,
		real_output: real_q, alternate_source_sel: src_q};
endmodule : dsm_chan_regs
`default_nettype wire

// File: logic/dsm_pkg.sv
// Purpose: constants and types for the down-conversion configuration bank
// Assumes: 32-bit APB, one register per aligned word
// Notes: byte address is four times the register index
package dsm_pkg;
	// register indices
	localparam logic [15:0] DSM_IDX_ENABLE = 16'h0000;
	localparam logic [15:0] DSM_IDX_DECIM = 16'h0001;
	localparam logic [15:0] DSM_IDX_DUAL = 16'h0002;
	localparam logic [15:0] DSM_IDX_REAL = 16'h0005;
	localparam logic [15:0] DSM_IDX_SOURCE = 16'h0006;
	localparam logic [15:0] DSM_IDX_SYSREF = 16'h003E;
	localparam logic [15:0] DSM_IDX_STATUS = 16'h003F;
	// channel page bases
	localparam logic [15:0] DSM_BASE_CHA = 16'h5000;
	localparam logic [15:0] DSM_BASE_CHB = 16'h5800;
	localparam logic [15:0] DSM_PAGE_SPAN = 16'h0800;
	// field positions
	localparam int DSM_BIT_ENABLE = 0;
	localparam int DSM_BIT_DUAL = 0;
	localparam int DSM_BIT_REAL = 0;
	localparam int DSM_BIT_SOURCE = 0;
	localparam int DSM_BIT_DIV_MASK = 6;
	localparam int DSM_BIT_OSC_MASK = 5;
	localparam int DSM_DECIM_W = 4;
	// reset values
	localparam logic [7:0] DSM_RST_CTRL = 8'h00;
	localparam logic [7:0] DSM_RST_SYSREF = 8'h00;
	// reserved-bit masks of each register except the status register
	localparam logic [7:0] DSM_RSV_ONEBIT = 8'hFE;
	localparam logic [7:0] DSM_RSV_DECIM = 8'hF0;
	localparam logic [7:0] DSM_RSV_SYSREF = 8'h9F;
	// unused decimation codes and the largest valid code
	localparam logic [3:0] DSM_DECIM_UNUSED_A = 4'h6;
	localparam logic [3:0] DSM_DECIM_UNUSED_B = 4'hB;
	localparam logic [3:0] DSM_DECIM_MAX = 4'hC;

	typedef struct packed {
		logic downconv_enable;
		logic [3:0] decimation_ratio_sel;
		logic dual_band;
		logic real_output;
		logic alternate_source_sel;
	} dsm_chan_cfg_t;

	typedef struct packed {
		logic divider_reset;
		logic oscillator_reset;
		logic lmfc_reset;
	} dsm_sync_t;
endpackage : dsm_pkg

// File: logic/dsm_top.sv
// Purpose: down-conversion configuration bank with sync masking
// Assumes: APB slave on pclk; sync input is asynchronous
// Notes: two channel pages plus the sync mask and status registers
//
// Functional notes
// - divider reset on sync rise when unmasked
// - masked divider ignores sync
// - unmasked: oscillator and LMFC reset on rise
// - masked: oscillator and LMFC ignore sync
// - channel pages at separate 16-bit bases
// - enable bit: 0 bypass, 1 filter
// - four-bit decimation ratio code select
// - dual-band bit selects one or two bands
// - real output at twice complex rate
// - source bit picks own or alternate converter
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module dsm_top
	import dsm_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// sync pin
	input wire logic sysref,
	// datapath control
	output dsm_chan_cfg_t cfg_a,
	output dsm_chan_cfg_t cfg_b,
	output dsm_sync_t sync_pulse,
	output logic rate_double_a,
	output logic rate_double_b
);
	// --------------------------------
	// address decode
	// --------------------------------
	logic [15:0] word_addr;
	logic sel_a, sel_b, sel_glob;
	logic [15:0] idx;
	logic setup;
	logic wr_go;

	assign word_addr = paddr[17:2];
	assign setup = psel && !penable;
	always_comb begin
		sel_a = 1'b0;
		sel_b = 1'b0;
		sel_glob = 1'b0;
		idx = word_addr;
		if (word_addr >= DSM_BASE_CHA && word_addr < DSM_BASE_CHA + DSM_PAGE_SPAN) begin
			sel_a = 1'b1;
			idx = word_addr - DSM_BASE_CHA;
		end else if (word_addr >= DSM_BASE_CHB
			&& word_addr < DSM_BASE_CHB + DSM_PAGE_SPAN) begin
			sel_b = 1'b1;
			idx = word_addr - DSM_BASE_CHB;
		end else begin
			sel_glob = 1'b1;
		end
	end

	// --------------------------------
	// channel pages
	// --------------------------------
	logic [7:0] rd_a, rd_b;
	logic hit_a, hit_b, bad_a, bad_b;
	dsm_chan_cfg_t cfg_a_w, cfg_b_w;

	dsm_chan_regs u_chan_a (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(wr_go && sel_a && pstrb[0]),
		.idx(idx),
		.wdata(pwdata[7:0]),
		.cfg(cfg_a_w),
		.rdata(rd_a),
		.hit(hit_a),
		.bad_write(bad_a)
	);

	dsm_chan_regs u_chan_b (
		.pclk(pclk),
		.presetn(presetn),
		.wr_en(wr_go && sel_b && pstrb[0]),
		.idx(idx),
		.wdata(pwdata[7:0]),
		.cfg(cfg_b_w),
		.rdata(rd_b),
		.hit(hit_b),
		.bad_write(bad_b)
	);

	// --------------------------------
	// sync mask and status
	// --------------------------------
	logic div_mask_q, osc_mask_q;
	logic rsv_err_q;
	logic glob_hit;
	logic [7:0] glob_rd;
	logic glob_bad;

	always_comb begin
		glob_hit = 1'b1;
		glob_rd = 8'h00;
		glob_bad = 1'b0;
		unique case (idx)
			DSM_IDX_SYSREF: begin
				glob_rd[DSM_BIT_DIV_MASK] = div_mask_q;
				glob_rd[DSM_BIT_OSC_MASK] = osc_mask_q;
				glob_bad = |(pwdata[7:0] & DSM_RSV_SYSREF);
			end
			DSM_IDX_STATUS: glob_rd = {7'h00, rsv_err_q};
			default: glob_hit = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_mask_q <= DSM_RST_SYSREF[DSM_BIT_DIV_MASK];
			osc_mask_q <= DSM_RST_SYSREF[DSM_BIT_OSC_MASK];
		end else if (wr_go && sel_glob && idx == DSM_IDX_SYSREF && pstrb[0]) begin
			div_mask_q <= pwdata[DSM_BIT_DIV_MASK];
			osc_mask_q <= pwdata[DSM_BIT_OSC_MASK];
		end
	end

	// sticky flag of unsupported reserved or code values
	logic bad_now;
	assign bad_now = (sel_a && bad_a) || (sel_b && bad_b) || (sel_glob && glob_bad);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsv_err_q <= 1'b0;
		end else if (wr_go && pstrb[0] && bad_now) begin
			rsv_err_q <= 1'b1;
		end else if (wr_go && sel_glob && idx == DSM_IDX_STATUS && pwdata[0]) begin
			rsv_err_q <= 1'b0;
		end
	end

	// --------------------------------
	// apb answer
	// --------------------------------
	logic hit_now;
	logic [7:0] rd_now;
	logic busy_q;

	assign hit_now = sel_a ? hit_a : (sel_b ? hit_b : glob_hit);
	assign rd_now = sel_a ? rd_a : (sel_b ? rd_b : glob_rd);
	// write lands on the access edge, no wait state
	assign wr_go = psel && penable && pwrite && busy_q && hit_now;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			busy_q <= 1'b0;
			if (setup) begin
				busy_q <= 1'b1;
				pready <= 1'b1;
				pslverr <= !hit_now;
				prdata <= (!pwrite && hit_now) ? {24'h00_0000, rd_now} : 32'h0000_0000;
			end
		end
	end

	// --------------------------------
	// sync edge detection
	// --------------------------------
	logic sref_s1_q, sref_s2_q, sref_s3_q;
	logic sref_rise;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sref_s1_q <= 1'b0;
			sref_s2_q <= 1'b0;
			sref_s3_q <= 1'b0;
		end else begin
			sref_s1_q <= sysref;
			sref_s2_q <= sref_s1_q;
			sref_s3_q <= sref_s2_q;
		end
	end

	assign sref_rise = sref_s2_q && !sref_s3_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_pulse <= '0;
		end else begin
			sync_pulse.divider_reset <= sref_rise && !div_mask_q;
			sync_pulse.oscillator_reset <= sref_rise && !osc_mask_q;
			sync_pulse.lmfc_reset <= sref_rise && !osc_mask_q;
		end
	end

	// --------------------------------
	// registered config outputs
	// --------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_a <= '0;
			cfg_b <= '0;
			rate_double_a <= 1'b0;
			rate_double_b <= 1'b0;
		end else begin
			cfg_a <= cfg_a_w;
			cfg_b <= cfg_b_w;
			rate_double_a <= cfg_a_w.downconv_enable && cfg_a_w.real_output;
			rate_double_b <= cfg_b_w.downconv_enable && cfg_b_w.real_output;
		end
	end
endmodule : dsm_top
`default_nettype wire

// File: testbench/dsm_top_asserts.sv
// Purpose: port-level checks of the configuration bank
// Assumes: apb master keeps one access cycle per setup
// Notes: sync held high 8 cycles and low longer by the bench
`timescale 1ns/1ns
`default_nettype none
module dsm_top_asserts
	import dsm_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// sync and config
	input wire logic sysref,
	input wire dsm_chan_cfg_t cfg_a,
	input wire dsm_chan_cfg_t cfg_b,
	input wire dsm_sync_t sync_pulse,
	input wire logic rate_double_a,
	input wire logic rate_double_b
);
	// ----------------
	// checks
	// ----------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	rdy_pulse_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	rdy_setup_a: assert property (psel && !penable |=> pready)
		else $error("no answer in first access cycle");
	err_rdy_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	unmapped_err_a: assert property (psel && !penable && paddr[17:2] == 16'h5003 |=> pslverr)
		else $error("unmapped index accepted");
	mapped_ok_a: assert property (psel && !penable && paddr[17:2] == 16'h5800 |=> !pslverr)
		else $error("mapped index refused");
	enable_write_a: assert property (psel && penable && pready && pwrite && pstrb[0]
		&& paddr[17:2] == 16'h5000 |-> ##2 cfg_a.downconv_enable == $past(pwdata[0], 2))
		else $error("enable bit not applied");
	ratio_write_b_a: assert property (psel && penable && pready && pwrite && pstrb[0]
		&& paddr[17:2] == 16'h5801 |-> ##2 cfg_b.decimation_ratio_sel == $past(pwdata[3:0], 2))
		else $error("ratio code not applied");
	rate_double_a_a: assert property ($stable(cfg_a) [*2] |->
		rate_double_a == (cfg_a.downconv_enable && cfg_a.real_output))
		else $error("rate flag mismatch");
	sync_pair_a: assert property (sync_pulse.oscillator_reset == sync_pulse.lmfc_reset)
		else $error("oscillator and lmfc pulses differ");
	sync_width_a: assert property (|sync_pulse |=> !(|sync_pulse))
		else $error("sync pulse too wide");
	sync_delay_a: assert property (|sync_pulse |-> $past(sysref, 3) && !$past(sysref, 8))
		else $error("sync pulse at wrong time");
endmodule : dsm_top_asserts
bind dsm_top dsm_top_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pstrb, .prdata, .pready, .pslverr, .sysref, .cfg_a, .cfg_b, .sync_pulse,
	.rate_double_a, .rate_double_b);
`default_nettype wire

// File: testbench/tb.sv
// Purpose: self-checking bench of the configuration bank
// Assumes: bench is the apb master and drives the sync pin
// Notes: expectations come from a shadow register model
`timescale 1ns/1ns
`default_nettype none
module tb;
	import dsm_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sysref = 0, clr = 0, er;
	logic [31:0] paddr = 0, pwdata = 0, rd, prdata;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, rate_double_a, rate_double_b;
	logic [2:0] seen = 0;
	logic [7:0] m [2][8];
	logic [3:0] codes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'hA, 4'hC};
	int offs [5] = '{0, 1, 2, 5, 6};
	int n_mismatch = 0, compares = 0;
	dsm_chan_cfg_t cfg_a, cfg_b;
	dsm_sync_t sync_pulse;
	dsm_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sysref(sysref), .cfg_a(cfg_a), .cfg_b(cfg_b),
		.sync_pulse(sync_pulse), .rate_double_a(rate_double_a), .rate_double_b(rate_double_b));
	// ----------------
	// helpers
	// ----------------
	initial forever #50 pclk = ~pclk;
	always @(posedge pclk) seen <= clr ? 3'h0 : seen | sync_pulse;
	function automatic dsm_chan_cfg_t exp_cfg(input int c);
		return {m[c][0][0], m[c][1][3:0], m[c][2][0], m[c][5][0], m[c][6][0]};
	endfunction : exp_cfg
	function automatic logic [31:0] adr(input int c, input int o);
		return 32'h14000 + c * 32'h2000 + 4 * o;
	endfunction : adr
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		chk(k < 20, 1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic cmp_cfg();
		repeat (2) @(posedge pclk);
		chk(cfg_a, exp_cfg(0));
		chk(cfg_b, exp_cfg(1));
		chk(rate_double_a, m[0][0][0] & m[0][5][0]);
		chk(rate_double_b, m[1][0][0] & m[1][5][0]);
	endtask : cmp_cfg
	task automatic tally_and_finish();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	initial begin
		#2000000;
		n_mismatch++;
		tally_and_finish();
	end
	// ----------------
	// tests
	// ----------------
	initial begin
		int c, o;
		logic [7:0] d;
		void'($urandom(32'h7c0d5c8c));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (c = 0; c < 2; c++)
			for (o = 0; o < 8; o++) begin
				m[c][o] = DSM_RST_CTRL;
				apb(0, adr(c, o), 0);
				chk(rd, 0);
				chk(er, o == 3 || o == 4 || o == 7);
			end
		apb(0, 32'hF8, 0);
		chk(rd, DSM_RST_SYSREF);
		foreach (codes[i]) begin
			m[0][1] = codes[i];
			apb(1, adr(0, 1), codes[i]);
			cmp_cfg();
		end
		m[0][1] = DSM_DECIM_UNUSED_A;
		apb(1, adr(0, 1), 32'(DSM_DECIM_UNUSED_A));
		apb(0, 32'hFC, 0);
		chk(rd, 1);
		apb(1, 32'hFC, 1);
		apb(0, 32'hFC, 0);
		chk(rd, 0);
		for (int i = 0; i < 40; i++) begin
			c = $urandom_range(1);
			o = offs[$urandom_range(4)];
			d = (o == 1) ? codes[$urandom_range(10)] : 8'($urandom_range(1));
			m[c][o] = d;
			apb(1, adr(c, o), d);
			apb(0, adr(c, o), 0);
			chk(rd, d);
			cmp_cfg();
		end
		pstrb <= 4'hE;
		apb(1, adr(1, 0), {7'h0, ~m[1][0][0]});
		pstrb <= 4'hF;
		apb(1, 32'h100, 1);
		chk(er, 1);
		apb(0, adr(1, 0), 0);
		chk(rd, m[1][0]);
		for (int k = 0; k < 4; k++) begin
			d = {1'b0, k[1:0], 5'h0};
			apb(1, 32'hF8, d);
			apb(0, 32'hF8, 0);
			chk(rd, d);
			clr <= 1;
			@(posedge pclk);
			clr <= 0;
			sysref <= 1;
			repeat (8) @(posedge pclk);
			sysref <= 0;
			repeat (12) @(posedge pclk);
			chk(seen, {~k[1], ~k[0], ~k[0]});
		end
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
